// ### inc/dgp_regs.vh
// register offsets, field positions, reset values for the dual analog-shared port
`ifndef DGP_REGS_VH
`define DGP_REGS_VH
`define DGP_ADDR_W            12
`define DGP_OFS_P6_LATCH      12'h006
`define DGP_OFS_P7_LATCH      12'h007
`define DGP_OFS_P6_DIR        12'h02e
`define DGP_OFS_P7_DIR        12'h02f
`define DGP_OFS_P6_PULLUP     12'hfbc
`define DGP_OFS_P7_PULLUP     12'hfbd
`define DGP_OFS_CONV_CTRL     12'h0e0
`define DGP_OFS_WAKE_CTRL     12'h0e1
`define DGP_RST_PORT          8'h00
`define DGP_RST_ANALOG_DIS    1'h1
`define DGP_RST_CHAN          4'h0
`define DGP_RST_WAKE_EN       4'h0
`define DGP_CONV_CHAN_LSB     0
`define DGP_CONV_CHAN_MSB     3
`define DGP_CONV_ANDIS_BIT    4
`define DGP_WAKE_EN_LSB       4
`define DGP_WAKE_EN_MSB       7
`endif

// ### src/dgp_port.v
// dual 8-bit gpio port with shared analog inputs and key wake-up pins
`timescale 1ns/10ps
//
// Overview of operation
// - two 8-bit ports, each pin individually input or output
// - reset clears direction and latch bits, sets analog-disable to one
// - reset configuration forces input data of every pin to zero
// - direction one drives pin from latch regardless of other settings
// - direction zero, latch one: digital input, read returns pin level
// - direction and latch zero, analog-disable one: read returns zero
// - direction and latch zero, analog-disable zero: analog input, reads zero
// - sampled converter channel comes from four-bit channel-select field
// - first port maps to channels 0-7, second to 8-15
// - pull-up follows its bit but never on an output pin
// - upper four pins of second port are key wake-up inputs, enabled per bit
`include "dgp_regs.vh"

module dgp_port #(
  parameter WIDTH = 8
) (
  input  wire                   SYS_CLK,
  input  wire                   RESETN,
  input  wire [`DGP_ADDR_W-1:0] ADDR,
  input  wire [7:0]             WDATA,
  input  wire                   WR,
  input  wire                   RD,
  output reg  [7:0]             RDATA,
  input  wire [WIDTH-1:0]       P6_IN,
  output reg  [WIDTH-1:0]       P6_OUT,
  output reg  [WIDTH-1:0]       P6_OE,
  output reg  [WIDTH-1:0]       P6_PULLUP,
  input  wire [WIDTH-1:0]       P7_IN,
  output reg  [WIDTH-1:0]       P7_OUT,
  output reg  [WIDTH-1:0]       P7_OE,
  output reg  [WIDTH-1:0]       P7_PULLUP,
  output reg  [2*WIDTH-1:0]     ANALOG_ROUTE,
  output reg  [3:0]             CONV_CHANNEL,
  output reg                    CONV_INPUT_VALID,
  output reg  [3:0]             KEY_WAKEUP_EN,
  output reg  [3:0]             KEY_WAKEUP_LEVEL
);

////////////////////////////////////////////////////////////////////////////////
// pin mode codes, one-hot
localparam [3:0] MODE_OUTPUT = 4'h1;
localparam [3:0] MODE_INPUT  = 4'h2;
localparam [3:0] MODE_FIXED0 = 4'h4;
localparam [3:0] MODE_ANALOG = 4'h8;
localparam       NWAKE       = 4;

// mode of one pin from direction, latch and analog-disable
function [3:0] pin_mode;
  input dir;
  input latch;
  input adis;
  begin
    if (dir) begin
      pin_mode = MODE_OUTPUT;
    end else if (latch) begin
      pin_mode = MODE_INPUT;
    end else if (adis) begin
      pin_mode = MODE_FIXED0;
    end else begin
      pin_mode = MODE_ANALOG;
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers
reg  [WIDTH-1:0] p6_latch_r;
reg  [WIDTH-1:0] p7_latch_r;
reg  [WIDTH-1:0] p6_dir_r;
reg  [WIDTH-1:0] p7_dir_r;
reg  [WIDTH-1:0] p6_pu_r;
reg  [WIDTH-1:0] p7_pu_r;
reg              analog_dis_r;
reg  [3:0]       chan_sel_r;
reg  [3:0]       wake_en_r;

////////////////////////////////////////////////////////////////////////////////
// address decode, exact match only
wire sel_p6_latch  = (ADDR == `DGP_OFS_P6_LATCH);
wire sel_p7_latch  = (ADDR == `DGP_OFS_P7_LATCH);
wire sel_p6_dir    = (ADDR == `DGP_OFS_P6_DIR);
wire sel_p7_dir    = (ADDR == `DGP_OFS_P7_DIR);
wire sel_p6_pu     = (ADDR == `DGP_OFS_P6_PULLUP);
wire sel_p7_pu     = (ADDR == `DGP_OFS_P7_PULLUP);
wire sel_conv      = (ADDR == `DGP_OFS_CONV_CTRL);
wire sel_wake      = (ADDR == `DGP_OFS_WAKE_CTRL);

// write enables
wire we_p6_latch   = WR & sel_p6_latch;
wire we_p7_latch   = WR & sel_p7_latch;
wire we_p6_dir     = WR & sel_p6_dir;
wire we_p7_dir     = WR & sel_p7_dir;
wire we_p6_pu      = WR & sel_p6_pu;
wire we_p7_pu      = WR & sel_p7_pu;
wire we_conv       = WR & sel_conv;
wire we_wake       = WR & sel_wake;

////////////////////////////////////////////////////////////////////////////////
// output latches
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    p6_latch_r <= `DGP_RST_PORT;
    p7_latch_r <= `DGP_RST_PORT;
  end else begin
    if (we_p6_latch) begin
      p6_latch_r <= WDATA;
    end
    if (we_p7_latch) begin
      p7_latch_r <= WDATA;
    end
  end
end

// direction bits, one selects output
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    p6_dir_r <= `DGP_RST_PORT;
    p7_dir_r <= `DGP_RST_PORT;
  end else begin
    if (we_p6_dir) begin
      p6_dir_r <= WDATA;
    end
    if (we_p7_dir) begin
      p7_dir_r <= WDATA;
    end
  end
end

// pull-up requests
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    p6_pu_r <= `DGP_RST_PORT;
    p7_pu_r <= `DGP_RST_PORT;
  end else begin
    if (we_p6_pu) begin
      p6_pu_r <= WDATA;
    end
    if (we_p7_pu) begin
      p7_pu_r <= WDATA;
    end
  end
end

// converter control
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    chan_sel_r   <= `DGP_RST_CHAN;
    analog_dis_r <= `DGP_RST_ANALOG_DIS;
  end else if (we_conv) begin
    chan_sel_r   <= WDATA[`DGP_CONV_CHAN_MSB:`DGP_CONV_CHAN_LSB];
    analog_dis_r <= WDATA[`DGP_CONV_ANDIS_BIT];
  end
end

// key wake-up enables
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    wake_en_r <= `DGP_RST_WAKE_EN;
  end else if (we_wake) begin
    wake_en_r <= WDATA[`DGP_WAKE_EN_MSB:`DGP_WAKE_EN_LSB];
  end
end

////////////////////////////////////////////////////////////////////////////////
// per-pin mode decode
wire [WIDTH-1:0]   p6_rd;
wire [WIDTH-1:0]   p7_rd;
wire [WIDTH-1:0]   p6_oe_nxt;
wire [WIDTH-1:0]   p7_oe_nxt;
wire [WIDTH-1:0]   p6_pu_nxt;
wire [WIDTH-1:0]   p7_pu_nxt;
wire [WIDTH-1:0]   p6_an_nxt;
wire [WIDTH-1:0]   p7_an_nxt;
wire [2*WIDTH-1:0] an_all;
wire [NWAKE-1:0]   wake_lvl_nxt;

genvar i;
generate
  for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
    wire [3:0] p6_mode = pin_mode(p6_dir_r[i], p6_latch_r[i], analog_dis_r);
    wire [3:0] p7_mode = pin_mode(p7_dir_r[i], p7_latch_r[i], analog_dis_r);
    reg        p6_rd_bit;
    reg        p7_rd_bit;

    // port 6 read value by mode
    always @* begin
      p6_rd_bit = 1'b0;
      case (p6_mode)
        MODE_OUTPUT: p6_rd_bit = p6_latch_r[i];
        MODE_INPUT:  p6_rd_bit = P6_IN[i];
        MODE_FIXED0: p6_rd_bit = 1'b0;
        MODE_ANALOG: p6_rd_bit = 1'b0;
        default:     p6_rd_bit = 1'b0;
      endcase
    end

    // port 7 read value by mode
    always @* begin
      p7_rd_bit = 1'b0;
      case (p7_mode)
        MODE_OUTPUT: p7_rd_bit = p7_latch_r[i];
        MODE_INPUT:  p7_rd_bit = P7_IN[i];
        MODE_FIXED0: p7_rd_bit = 1'b0;
        MODE_ANALOG: p7_rd_bit = 1'b0;
        default:     p7_rd_bit = 1'b0;
      endcase
    end

    // pin drive, pull-up and analog routing
    assign p6_rd[i]         = p6_rd_bit;
    assign p7_rd[i]         = p7_rd_bit;
    assign p6_oe_nxt[i]     = (p6_mode == MODE_OUTPUT);
    assign p7_oe_nxt[i]     = (p7_mode == MODE_OUTPUT);
    assign p6_pu_nxt[i]     = p6_pu_r[i] & (p6_mode != MODE_OUTPUT);
    assign p7_pu_nxt[i]     = p7_pu_r[i] & (p7_mode != MODE_OUTPUT);
    assign p6_an_nxt[i]     = (p6_mode == MODE_ANALOG);
    assign p7_an_nxt[i]     = (p7_mode == MODE_ANALOG);
    assign an_all[i]        = p6_an_nxt[i];
    assign an_all[WIDTH+i]  = p7_an_nxt[i];

    // upper pins of port 7 double as key wake-up inputs
    if (i >= WIDTH-NWAKE) begin : g_wake
      assign wake_lvl_nxt[i-(WIDTH-NWAKE)] = P7_IN[i] & wake_en_r[i-(WIDTH-NWAKE)];
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// read mux
reg [7:0] rdata_nxt;

always @* begin
  rdata_nxt = 8'h00;
  if (sel_p6_latch) begin
    rdata_nxt = p6_rd;
  end
  if (sel_p7_latch) begin
    rdata_nxt = p7_rd;
  end
  if (sel_p6_dir) begin
    rdata_nxt = p6_dir_r;
  end
  if (sel_p7_dir) begin
    rdata_nxt = p7_dir_r;
  end
  if (sel_p6_pu) begin
    rdata_nxt = p6_pu_r;
  end
  if (sel_p7_pu) begin
    rdata_nxt = p7_pu_r;
  end
  if (sel_conv) begin
    rdata_nxt = {3'h0, analog_dis_r, chan_sel_r};
  end
  if (sel_wake) begin
    rdata_nxt = {wake_en_r, 4'h0};
  end
end

////////////////////////////////////////////////////////////////////////////////
// output flops
// read data, zero outside the answer cycle
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    RDATA <= 8'h00;
  end else begin
    RDATA <= RD ? rdata_nxt : 8'h00;
  end
end

// port 6 pin drive
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    P6_OUT    <= {WIDTH{1'b0}};
    P6_OE     <= {WIDTH{1'b0}};
    P6_PULLUP <= {WIDTH{1'b0}};
  end else begin
    P6_OUT    <= p6_latch_r;
    P6_OE     <= p6_oe_nxt;
    P6_PULLUP <= p6_pu_nxt;
  end
end

// port 7 pin drive
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    P7_OUT    <= {WIDTH{1'b0}};
    P7_OE     <= {WIDTH{1'b0}};
    P7_PULLUP <= {WIDTH{1'b0}};
  end else begin
    P7_OUT    <= p7_latch_r;
    P7_OE     <= p7_oe_nxt;
    P7_PULLUP <= p7_pu_nxt;
  end
end

// analog routing to the converter
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    ANALOG_ROUTE <= {2*WIDTH{1'b0}};
  end else begin
    ANALOG_ROUTE <= an_all;
  end
end

// selected converter channel
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    CONV_CHANNEL     <= 4'h0;
    CONV_INPUT_VALID <= 1'b0;
  end else begin
    CONV_CHANNEL     <= chan_sel_r;
    CONV_INPUT_VALID <= an_all[chan_sel_r];
  end
end

// key wake-up enables
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    KEY_WAKEUP_EN <= 4'h0;
  end else begin
    KEY_WAKEUP_EN <= wake_en_r;
  end
end

// key wake-up levels
always @(posedge SYS_CLK or negedge RESETN) begin
  if (!RESETN) begin
    KEY_WAKEUP_LEVEL <= 4'h0;
  end else begin
    KEY_WAKEUP_LEVEL <= wake_lvl_nxt;
  end
end

endmodule

// ### testbench/dgp_pins.sv
// pin-side model of one 8-pin port
`timescale 1ns/10ps
module dgp_pins (
  input  wire [7:0] o, oe, pu, ext,
  input  wire       ext_en,
  output wire [7:0] pin
);
  // own drive, else outside level, else pull-up or floating junk
  assign pin = (oe & o) | (~oe & (ext_en ? ext : (pu | ~o)));
endmodule

// ### testbench/dgp_port_props.sv
// assertions on the dual port outputs and reads
`timescale 1ns/10ps
module dgp_port_props (
  input wire        SYS_CLK, RESETN, WR, RD, CONV_INPUT_VALID,
  input wire [11:0] ADDR,
  input wire [7:0]  RDATA, P6_OUT, P6_OE, P6_PULLUP, P7_OUT, P7_OE, P7_PULLUP,
  input wire [15:0] ANALOG_ROUTE,
  input wire [3:0]  CONV_CHANNEL, KEY_WAKEUP_EN, KEY_WAKEUP_LEVEL
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  reg  wr_r;
  wire q6 = RD && ADDR == 12'h006 && !wr_r;
  always @(posedge SYS_CLK or negedge RESETN)
    if (!RESETN) wr_r <= 1'b0;
    else wr_r <= WR;
  ////////////////////////////////////////////////////////////////
  rst_cfg_a: assert property (!$past(RESETN) |-> {P6_OE, P7_OE, P6_OUT, ANALOG_ROUTE} == 0)
    else $error("bad reset state");
  pu6_out_a: assert property ((P6_PULLUP & P6_OE) == 0) else $error("pull-up on output");
  pu7_out_a: assert property ((P7_PULLUP & P7_OE) == 0) else $error("pull-up on output");
  an_pin_a: assert property ((ANALOG_ROUTE & {P7_OE | P7_OUT, P6_OE | P6_OUT}) == 0)
    else $error("bad analog route");
  chan_ok_a: assert property (CONV_INPUT_VALID == ANALOG_ROUTE[CONV_CHANNEL])
    else $error("bad channel valid");
  wake_en_a: assert property ((KEY_WAKEUP_LEVEL & ~KEY_WAKEUP_EN) == 0) else $error("bad wake level");
  rd_idle_a: assert property (!$past(RD) |-> RDATA == 0) else $error("stale read data");
  rd_out_a: assert property (q6 && P6_OE == 8'hff |=> RDATA == $past(P6_OUT))
    else $error("bad output read");
  rd_zero_a: assert property (q6 && P6_OE == 0 && P6_OUT == 0 |=> RDATA == 0)
    else $error("bad zero read");
  cover property (q6 && P6_OE == 8'hff);
  cover property (CONV_INPUT_VALID);
  cover property (KEY_WAKEUP_LEVEL != 0);
endmodule
bind dgp_port dgp_port_props i_props (.*);

// ### testbench/dgp_port_tb.sv
// self-checking bench for the dual analog-shared port
`timescale 1ns/10ps
module dgp_port_tb;
  reg         SYS_CLK = 0, RESETN = 0, WR = 0, RD = 0;
  reg  [11:0] ADDR = 0;
  reg  [7:0]  WDATA = 0, ext = 8'hff;
  wire [7:0]  RDATA, P6_IN, P6_OUT, P6_OE, P6_PULLUP, P7_IN, P7_OUT, P7_OE, P7_PULLUP;
  wire [15:0] ANALOG_ROUTE;
  wire [3:0]  CONV_CHANNEL, KEY_WAKEUP_EN, KEY_WAKEUP_LEVEL;
  wire        CONV_INPUT_VALID;
  integer     error_cnt = 0, comparisons = 0, i, p;
  reg  [31:0] rows [0:3];
  always #4 SYS_CLK = ~SYS_CLK;
  dgp_port i_dut (.*);
  dgp_pins i_p6 (.o(P6_OUT), .oe(P6_OE), .pu(P6_PULLUP), .ext(ext), .ext_en(1'b1), .pin(P6_IN));
  dgp_pins i_p7 (.o(P7_OUT), .oe(P7_OE), .pu(P7_PULLUP), .ext(ext), .ext_en(1'b1), .pin(P7_IN));
  ////////////////////////////////////////////////////////////////
  task chk(input [15:0] got, input [15:0] exp); begin
    comparisons = comparisons + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task wr_reg(input [11:0] a, input [7:0] d); begin
    @(posedge SYS_CLK); WR <= 1; ADDR <= a; WDATA <= d;
    @(posedge SYS_CLK); WR <= 0;
    repeat (3) @(posedge SYS_CLK);
  end endtask
  task rd_chk(input [11:0] a, input [7:0] e); begin
    @(posedge SYS_CLK); RD <= 1; ADDR <= a;
    @(posedge SYS_CLK); RD <= 0;
    #1 chk(RDATA, e);
  end endtask
  task print_verdict; begin
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = 32'hffa5_3ca5;
    rows[1] = 32'h00ff_3c3c;
    rows[2] = 32'h0000_ff00;
    rows[3] = 32'h0f33_c003;
    repeat (16) @(posedge SYS_CLK);
    RESETN <= 1;
    rd_chk(12'h006, 8'h00);
    rd_chk(12'h007, 8'h00);
    rd_chk(12'h02e, 8'h00);
    rd_chk(12'hfbd, 8'h00);
    rd_chk(12'h0e0, 8'h10);
    rd_chk(12'h123, 8'h00);
    for (p = 0; p < 2; p = p + 1)
      for (i = 0; i < 4; i = i + 1) begin
        ext <= rows[i][15:8];
        wr_reg(12'h02e + p[11:0], rows[i][31:24]);
        wr_reg(12'h006 + p[11:0], rows[i][23:16]);
        rd_chk(12'h006 + p[11:0], rows[i][7:0]);
      end
    wr_reg(12'h02e, 8'h00);
    wr_reg(12'h006, 8'h00);
    wr_reg(12'h02f, 8'h00);
    wr_reg(12'h007, 8'h01);
    wr_reg(12'h0e0, 8'h09);
    chk(ANALOG_ROUTE, 16'hfeff);
    chk(CONV_CHANNEL, 4'h9);
    chk(CONV_INPUT_VALID, 1'b1);
    rd_chk(12'h006, 8'h00);
    wr_reg(12'h0e0, 8'h08);
    chk(CONV_INPUT_VALID, 1'b0);
    wr_reg(12'hfbc, 8'hff);
    wr_reg(12'h02e, 8'h0f);
    wr_reg(12'h007, 8'hff);
    ext <= 8'hf0;
    wr_reg(12'h0e1, 8'h30);
    chk(P6_PULLUP, 8'hf0);
    chk(KEY_WAKEUP_EN, 4'h3);
    chk(KEY_WAKEUP_LEVEL, 4'h3);
    chk(P6_OE, 8'h0f);
    chk(P6_OUT, 8'h00);
    chk(P7_OE, 8'h00);
    chk(P7_OUT, 8'hff);
    chk(P7_PULLUP, 8'h00);
    @(posedge SYS_CLK); RESETN <= 0;
    @(posedge SYS_CLK); RESETN <= 1;
    #1 chk({P6_OE, P7_OUT}, 16'h0000);
    chk(KEY_WAKEUP_EN, 4'h0);
    rd_chk(12'h0e0, 8'h10);
    rd_chk(12'h02e, 8'h00);
    rd_chk(12'h007, 8'h00);
    print_verdict;
  end
endmodule
